// ---- core/i2ctd_pkg.sv ----
/*
  shared types and constants of the two-wire bus trigger decoder.
  assumes nothing beyond a sv-2012 compiler.
*/
`default_nettype none
package i2ctd_pkg;
	// -------------------------------------------------------------
	// bus and pattern figures
	// -------------------------------------------------------------
	localparam int         NCH        = 4;       // observed input channels
	localparam int         SRC_W      = 2;       // channel select width
	localparam logic [4:0] TEN_PREFIX = 5'h1e;   // long-form address prefix
	localparam logic [3:0] BIT_LAST   = 4'h7;    // index of last data bit
	localparam logic       RW_RD      = 1'b1;    // direction bit value for read
	localparam int         PAT_W      = 64;      // data pattern width
	localparam logic [1:0] BNO_MAX    = 2'h3;    // byte count saturates here
	localparam logic [7:0] DCNT_MAX   = 8'hff;   // skip counter saturates here

	// -------------------------------------------------------------
	// enumerations
	// -------------------------------------------------------------
	typedef enum logic [2:0] {
		EV_START  = 3'b000,
		EV_RSTART = 3'b001,
		EV_STOP   = 3'b010,
		EV_ADDR   = 3'b011,
		EV_AHI    = 3'b100,
		EV_DATA   = 3'b101,
		EV_ABORT  = 3'b110
	} i2ctd_kind_e;

	typedef enum logic [2:0] {
		TT_START     = 3'b000,
		TT_RSTART    = 3'b001,
		TT_STOP      = 3'b010,
		TT_NACK      = 3'b011,
		TT_ADDR      = 3'b100,
		TT_DATA      = 3'b101,
		TT_ADDR_DATA = 3'b110
	} i2ctd_trig_e;

	typedef enum logic [1:0] {
		RW_EITHER = 2'b00,
		RW_WRITE  = 2'b01,
		RW_READ   = 2'b10
	} i2ctd_rw_e;

	typedef enum logic [1:0] {
		LS_IDLE = 2'b00,
		LS_BITS = 2'b01,
		LS_ACK  = 2'b10
	} i2ctd_ls_e;

	// one decoded bus event
	typedef struct packed {
		i2ctd_kind_e kind;
		logic [7:0]  data;
		logic        ack;
		logic        rw;
		logic        is10;
		logic [9:0]  addr;
		logic        incomp;
	} i2ctd_ev_s;
endpackage
`default_nettype wire

// ---- core/i2ctd_ev_if.sv ----
/*
  event carrier from the link-clock decoder to the system-clock side.
  assumes the sender changes ev only together with a tgl flip.
*/
`default_nettype none
interface i2ctd_ev_if import i2ctd_pkg::*; ();
	i2ctd_ev_s ev;
	logic      tgl;

	modport src (output ev, output tgl);
	modport dst (input ev, input tgl);
endinterface
`default_nettype wire

// ---- core/i2ctd_pins.sv ----
/*
  link-clock front end: reset release, input synchronisers, line select.
  assumes channel pins and config levels are asynchronous to acq_clk.
*/
`default_nettype none
module i2ctd_pins import i2ctd_pkg::*;
(
	input  wire logic             acq_clk,
	input  wire logic             rst,
	input  wire logic [NCH-1:0]   ch_in,
	input  wire logic             dec_en,
	input  wire logic [SRC_W-1:0] scl_src,
	input  wire logic [SRC_W-1:0] sda_src,
	output logic                  l_rst,
	output logic                  l_en,
	output logic                  l_scl,
	output logic                  l_sda
);
	localparam int SW = 1 + 2 * SRC_W + NCH;

	logic [1:0]    rs_q;
	logic [1:0]    rs_d;
	logic [SW-1:0] s1_q;
	logic [SW-1:0] s1_d;
	logic [SW-1:0] s2_q;
	logic [SW-1:0] s2_d;
	logic          en_d;
	logic          scl_d;
	logic          sda_d;

	// reset release and two-stage sync, then the chosen lines
	always_comb
	begin
		rs_d  = {rs_q[0], 1'b0};
		s1_d  = {dec_en, scl_src, sda_src, ch_in};
		s2_d  = s1_q;
		en_d  = s2_q[SW-1];
		scl_d = s2_q[s2_q[NCH+2*SRC_W-1 -: SRC_W]];
		sda_d = s2_q[s2_q[NCH+SRC_W-1 -: SRC_W]];
	end

	always_ff @(posedge acq_clk or posedge rst)
	begin
		if (rst)
			rs_q <= 2'h3;
		else
			rs_q <= rs_d;
	end

	assign l_rst = rs_q[1];

	// acq_clk must run well above the fastest bus grade in use
	always_ff @(posedge acq_clk or posedge l_rst)
	begin
		if (l_rst)
		begin
			s1_q  <= '0;
			s2_q  <= '0;
			l_en  <= 1'b0;
			l_scl <= 1'b1;
			l_sda <= 1'b1;
		end
		else
		begin
			s1_q  <= s1_d;
			s2_q  <= s2_d;
			l_en  <= en_d;
			l_scl <= scl_d;
			l_sda <= sda_d;
		end
	end
endmodule
`default_nettype wire

// ---- core/i2ctd_xing.sv ----
/*
  toggle crossing of decoded events into the ref_clk domain.
  assumes events are spaced by more than four ref_clk cycles.
*/
`default_nettype none
module i2ctd_xing import i2ctd_pkg::*;
(
	input  wire logic  ref_clk,
	input  wire logic  rst,
	i2ctd_ev_if.dst    evi,
	output logic       x_vld,
	output i2ctd_ev_s  x_ev
);
	logic [2:0] t_q;
	logic [2:0] t_d;
	logic       vld_d;
	i2ctd_ev_s  ev_d;

	// third stage gives the flip; word is stable once tgl is seen
	always_comb
	begin
		t_d   = {t_q[1:0], evi.tgl};
		vld_d = t_q[2] ^ t_q[1];
		ev_d  = vld_d ? evi.ev : x_ev;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			t_q   <= '0;
			x_vld <= 1'b0;
			x_ev  <= '0;
		end
		else
		begin
			t_q   <= t_d;
			x_vld <= vld_d;
			x_ev  <= ev_d;
		end
	end
endmodule
`default_nettype wire

// ---- core/i2ctd_top.sv ----
/*
  passive two-wire bus monitor: decodes conditions, addresses and bytes
  on the acquisition clock and raises triggers on ref_clk.
  assumes acq_clk free-running and much faster than the bus bit rate.
*/
// How it works
// - sda falling while scl high is a start condition.
// - sda rising while scl high is a stop and ends the message.
// - direction bit one means master reads, zero means master writes.
// - short address byte is seven address bits then direction bit.
// - long write address is prefix, two high bits, write, then low byte.
// - long read address adds a third prefix byte with read bit.
// - triggers on start, stop, repeated start, address with direction, nack, pattern.
// - only the physical channel inputs feed decode and trigger.
// - all bus speed grades are decoded.
// - clock and data lines each have their own channel select.
// - decoding runs only while the bus enable is on.
// - a start without stop since the last start is a repeated start.
// - nack is data high through the clock pulse after a byte.
// - address trigger instant is scl falling at the ack bit.
// - pattern up to 64 bits, msb first, matched byte by byte.
`default_nettype none
module i2ctd_top import i2ctd_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             acq_clk,
	input  wire logic [NCH-1:0]   ch_in,
	input  wire logic             dec_en,
	input  wire logic [SRC_W-1:0] scl_src,
	input  wire logic [SRC_W-1:0] sda_src,
	input  wire i2ctd_trig_e      trig_type,
	input  wire i2ctd_rw_e        rw_cond,
	input  wire logic             addr_10bit,
	input  wire logic [9:0]       addr_val,
	input  wire logic             nack_addr_en,
	input  wire logic             nack_wr_en,
	input  wire logic             nack_rd_en,
	input  wire logic [PAT_W-1:0] data_pat,
	input  wire logic [3:0]       data_len,
	input  wire logic [7:0]       data_index,
	output logic                  trig_q,
	output logic                  ev_vld,
	output i2ctd_ev_s             ev_out
);
	// -------------------------------------------------------------
	// functions
	// -------------------------------------------------------------
	function automatic i2ctd_ev_s mk_ev(i2ctd_kind_e k, logic [7:0] b, logic a,
		logic r, logic t, logic [9:0] ad, logic inc);
		i2ctd_ev_s e;
		e.kind   = k;
		e.data   = b;
		e.ack    = a;
		e.rw     = r;
		e.is10   = t;
		e.addr   = ad;
		e.incomp = inc;
		return e;
	endfunction

	// byte k of the pattern, the first byte being the most significant
	function automatic logic [7:0] pat_byte(logic [PAT_W-1:0] p, logic [3:0] len,
		logic [3:0] k);
		logic [3:0] i;
		i = len - k - 4'h1;
		return p[{i[2:0], 3'b000} +: 8];
	endfunction

	// -------------------------------------------------------------
	// link-clock front end and event carrier
	// -------------------------------------------------------------
	logic l_rst;
	logic l_en;
	logic l_scl;
	logic l_sda;

	i2ctd_ev_if ev_bus ();

	i2ctd_pins u_pins (
		.acq_clk (acq_clk),
		.rst     (rst),
		.ch_in   (ch_in),
		.dec_en  (dec_en),
		.scl_src (scl_src),
		.sda_src (sda_src),
		.l_rst   (l_rst),
		.l_en    (l_en),
		.l_scl   (l_scl),
		.l_sda   (l_sda)
	);

	// -------------------------------------------------------------
	// bus decoder on acq_clk
	// -------------------------------------------------------------
	i2ctd_ls_e  st_q, st_d;
	logic [3:0] bits_q, bits_d;
	logic [7:0] sh_q, sh_d;
	logic       nack_q, nack_d;
	logic [1:0] bno_q, bno_d;
	logic       frm_q, frm_d;
	logic       is10_q, is10_d;
	logic       rw_q, rw_d;
	logic [1:0] ahi_q, ahi_d;
	logic [7:0] alo_q, alo_d;
	logic       scl_p_q;
	logic       sda_p_q;
	i2ctd_ev_s  ev_q, ev_d;
	logic       tgl_q, tgl_d;
	logic       start_c;
	logic       stop_c;
	logic       rise_c;
	logic       fall_c;
	logic       ack_fall;
	logic       mid_c;

	// line conditions from this and the previous sample
	assign start_c  = l_scl && scl_p_q && sda_p_q && !l_sda;
	assign stop_c   = l_scl && scl_p_q && !sda_p_q && l_sda;
	assign rise_c   = l_scl && !scl_p_q;
	assign fall_c   = !l_scl && scl_p_q;
	// the byte closes only after the ninth pulse has risen (bits_q marks it in LS_ACK)
	assign ack_fall = (st_q == LS_ACK) && fall_c && (bits_q != 4'h0);
	// one shifted pulse is the condition's own clock, not a cut byte
	assign mid_c    = (st_q == LS_ACK) || (bits_q > 4'h1);

	// next state of the decoder
	always_comb
	begin
		st_d   = st_q;
		bits_d = bits_q;
		sh_d   = sh_q;
		nack_d = nack_q;
		bno_d  = bno_q;
		frm_d  = frm_q;
		is10_d = is10_q;
		rw_d   = rw_q;
		ahi_d  = ahi_q;
		alo_d  = alo_q;
		ev_d   = ev_q;
		tgl_d  = tgl_q;
		if (!l_en)
		begin
			// disabling ends capture; an open frame is reported cut
			if (frm_q)
			begin
				ev_d  = mk_ev(EV_ABORT, sh_q, 1'b0, rw_q, is10_q, 10'h000, 1'b1);
				tgl_d = !tgl_q;
			end
			st_d   = LS_IDLE;
			frm_d  = 1'b0;
			bits_d = 4'h0;
		end
		else if (start_c)
		begin
			// open frame at start means repeated start
			ev_d   = mk_ev(frm_q ? EV_RSTART : EV_START, sh_q, 1'b0, rw_q, is10_q,
				10'h000, frm_q && mid_c);
			tgl_d  = !tgl_q;
			frm_d  = 1'b1;
			st_d   = LS_BITS;
			bits_d = 4'h0;
			bno_d  = 2'h0;
		end
		else if (stop_c)
		begin
			ev_d   = mk_ev(EV_STOP, sh_q, 1'b0, rw_q, is10_q, 10'h000, frm_q && mid_c);
			tgl_d  = !tgl_q;
			frm_d  = 1'b0;
			st_d   = LS_IDLE;
			bits_d = 4'h0;
		end
		else if (st_q == LS_BITS && rise_c)
		begin
			// shift data msb first on each rising clock
			sh_d   = {sh_q[6:0], l_sda};
			bits_d = (bits_q == BIT_LAST) ? 4'h0 : bits_q + 4'h1;
			if (bits_q == BIT_LAST)
				st_d = LS_ACK;
		end
		else if (st_q == LS_ACK)
		begin
			// receiver drives the ninth bit; high all pulse long is nack
			if (rise_c)
			begin
				nack_d = l_sda;
				bits_d = 4'h1;                                       // ninth pulse seen
			end
			else if (l_scl && !l_sda)
				nack_d = 1'b0;
			if (ack_fall)
			begin
				// byte is closed at the falling clock of its ack bit
				st_d   = LS_BITS;
				bits_d = 4'h0;
				tgl_d = !tgl_q;
				bno_d = (bno_q == BNO_MAX) ? bno_q : bno_q + 2'h1;
				if (bno_q == 2'h0)
				begin
					rw_d = sh_q[0];
					if (sh_q[7:3] == TEN_PREFIX)
					begin
						is10_d = 1'b1;
						ahi_d  = sh_q[2:1];
						// prefix with read bit completes a long read address
						ev_d = mk_ev(sh_q[0] == RW_RD ? EV_ADDR : EV_AHI, sh_q, !nack_q,
							sh_q[0], 1'b1, {sh_q[2:1], alo_q}, 1'b0);
					end
					else
					begin
						is10_d = 1'b0;
						ev_d   = mk_ev(EV_ADDR, sh_q, !nack_q, sh_q[0], 1'b0,
							{3'b000, sh_q[7:1]}, 1'b0);
					end
				end
				else if (bno_q == 2'h1 && is10_q && rw_q != RW_RD)
				begin
					alo_d = sh_q;
					ev_d  = mk_ev(EV_ADDR, sh_q, !nack_q, rw_q, 1'b1,
						{ahi_q, sh_q}, 1'b0);
				end
				else
					ev_d = mk_ev(EV_DATA, sh_q, !nack_q, rw_q, is10_q, 10'h000, 1'b0);
			end
		end
	end

	// decoder registers
	always_ff @(posedge acq_clk or posedge l_rst)
	begin
		if (l_rst)
		begin
			st_q    <= LS_IDLE;
			bits_q  <= 4'h0;
			sh_q    <= 8'h00;
			nack_q  <= 1'b1;
			bno_q   <= 2'h0;
			frm_q   <= 1'b0;
			is10_q  <= 1'b0;
			rw_q    <= 1'b0;
			ahi_q   <= 2'h0;
			alo_q   <= 8'h00;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			ev_q    <= '0;
			tgl_q   <= 1'b0;
		end
		else
		begin
			st_q    <= st_d;
			bits_q  <= bits_d;
			sh_q    <= sh_d;
			nack_q  <= nack_d;
			bno_q   <= bno_d;
			frm_q   <= frm_d;
			is10_q  <= is10_d;
			rw_q    <= rw_d;
			ahi_q   <= ahi_d;
			alo_q   <= alo_d;
			scl_p_q <= l_scl;
			sda_p_q <= l_sda;
			ev_q    <= ev_d;
			tgl_q   <= tgl_d;
		end
	end

	assign ev_bus.ev  = ev_q;
	assign ev_bus.tgl = tgl_q;

	// -------------------------------------------------------------
	// crossing into ref_clk
	// -------------------------------------------------------------
	i2ctd_xing u_xing (
		.ref_clk (ref_clk),
		.rst     (rst),
		.evi     (ev_bus),
		.x_vld   (ev_vld),
		.x_ev    (ev_out)
	);

	// -------------------------------------------------------------
	// trigger unit on ref_clk
	// -------------------------------------------------------------
	logic       trig_d;
	logic       aok_q, aok_d;
	logic [7:0] dcnt_q, dcnt_d;
	logic [3:0] pos_q, pos_d;
	logic       a_hit;
	logic       b_eq;
	logic       p_hit;
	logic       nk;

	// address and direction match of the crossed event
	assign a_hit = (ev_out.is10 == addr_10bit)
		&& (addr_10bit ? ev_out.addr == addr_val : ev_out.addr[6:0] == addr_val[6:0])
		&& (rw_cond == RW_EITHER || (rw_cond == RW_READ && ev_out.rw == RW_RD)
		|| (rw_cond == RW_WRITE && ev_out.rw != RW_RD));
	assign b_eq  = ev_out.data == pat_byte(data_pat, data_len, pos_q);
	assign p_hit = b_eq && (pos_q + 4'h1 == data_len) && dcnt_q >= data_index;
	assign nk    = !ev_out.ack && trig_type == TT_NACK;

	// trigger decision per event
	always_comb
	begin
		trig_d = 1'b0;
		aok_d  = aok_q;
		dcnt_d = dcnt_q;
		pos_d  = pos_q;
		if (ev_vld)
		begin
			case (ev_out.kind)
				EV_START:  trig_d = trig_type == TT_START;
				EV_RSTART: trig_d = trig_type == TT_RSTART;
				EV_STOP:   trig_d = trig_type == TT_STOP;
				EV_AHI:    trig_d = nk && nack_addr_en;
				EV_ADDR:
				begin
					aok_d  = a_hit;
					dcnt_d = 8'h00;
					pos_d  = 4'h0;
					trig_d = (trig_type == TT_ADDR && a_hit) || (nk && nack_addr_en);
				end
				EV_DATA:
				begin
					dcnt_d = (dcnt_q == DCNT_MAX) ? dcnt_q : dcnt_q + 8'h01;
					if (dcnt_q >= data_index)
					begin
						// restart the match on a miss, compare this byte as first
						if (p_hit)
							pos_d = 4'h0;
						else if (b_eq)
							pos_d = pos_q + 4'h1;
						else
							pos_d = {3'b000, ev_out.data == pat_byte(data_pat, data_len, 4'h0)};
					end
					// read nack closes a read normally; only reported when asked
					trig_d = (trig_type == TT_DATA && p_hit)
						|| (trig_type == TT_ADDR_DATA && p_hit && aok_q)
						|| (nk && (ev_out.rw == RW_RD ? nack_rd_en : nack_wr_en));
				end
				default:   trig_d = 1'b0;
			endcase
		end
	end

	// trigger registers
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			trig_q <= 1'b0;
			aok_q  <= 1'b0;
			dcnt_q <= 8'h00;
			pos_q  <= 4'h0;
		end
		else
		begin
			trig_q <= trig_d;
			aok_q  <= aok_d;
			dcnt_q <= dcnt_d;
			pos_q  <= pos_d;
		end
	end

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	a_start_seen: assert property (@(posedge acq_clk) disable iff (l_rst)
		(l_en && start_c) |=> ($changed(tgl_q) && (ev_q.kind == EV_START
		|| ev_q.kind == EV_RSTART)))
		else $error("start condition not reported");
	a_stop_seen: assert property (@(posedge acq_clk) disable iff (l_rst)
		(l_en && stop_c) |=> ($changed(tgl_q) && ev_q.kind == EV_STOP && !frm_q))
		else $error("stop condition not reported or frame left open");
	a_rstart_class: assert property (@(posedge acq_clk) disable iff (l_rst)
		(l_en && start_c && frm_q) |=> ev_q.kind == EV_RSTART)
		else $error("repeated start misclassified");
	a_ack_instant: assert property (@(posedge acq_clk) disable iff (l_rst)
		(l_en && ack_fall) |=> ($changed(tgl_q) && st_q == LS_BITS))
		else $error("byte not closed at ack falling clock");
	a_nack_level: assert property (@(posedge acq_clk) disable iff (l_rst)
		(l_en && ack_fall) |=> ev_q.ack == !$past(nack_q))
		else $error("ack flag does not follow ack bit");
	a_short_addr: assert property (@(posedge acq_clk) disable iff (l_rst)
		(l_en && ack_fall && bno_q == 2'h0 && sh_q[7:3] != TEN_PREFIX) |=>
		(ev_q.kind == EV_ADDR && ev_q.addr[6:0] == $past(sh_q[7:1])
		&& ev_q.rw == $past(sh_q[0])))
		else $error("short address split wrong");
	a_long_addr: assert property (@(posedge acq_clk) disable iff (l_rst)
		(l_en && ack_fall && bno_q == 2'h1 && is10_q && !rw_q) |=>
		(ev_q.kind == EV_ADDR && ev_q.addr == {$past(ahi_q), $past(sh_q)}))
		else $error("long address assembled wrong");
	a_disabled_idle: assert property (@(posedge acq_clk) disable iff (l_rst)
		(!l_en) [*3] |-> (st_q == LS_IDLE && !frm_q && $stable(tgl_q)))
		else $error("decoding while disabled");
	a_cut_frame: assert property (@(posedge acq_clk) disable iff (l_rst)
		(l_en && start_c && frm_q && bits_q > 4'h1) |=> ev_q.incomp)
		else $error("cut frame not flagged");
	a_start_trig: assert property (@(posedge ref_clk) disable iff (rst)
		(ev_vld && ev_out.kind == EV_START && trig_type == TT_START) |=> trig_q)
		else $error("start trigger missed");

	c_rstart: cover property (@(posedge acq_clk) disable iff (l_rst)
		l_en && start_c && frm_q);
	c_long_read: cover property (@(posedge acq_clk) disable iff (l_rst)
		l_en && ack_fall && bno_q == 2'h0 && sh_q[7:3] == TEN_PREFIX && sh_q[0]);
	c_pat_trig: cover property (@(posedge ref_clk) disable iff (rst)
		ev_vld && ev_out.kind == EV_DATA && p_hit);
endmodule
`default_nettype wire

// ---- dv/i2ctd_bus_bfm.sv ----
/*
  behavioural two-wire bus: one master and one slave on open-drain lines.
  assumes the bench calls one task at a time and reads scl/sda as levels.
*/
`default_nettype none
module i2ctd_bus_bfm
(
	output var logic scl,
	output var logic sda
);
	timeunit 1ns;
	timeprecision 100ps;
	// ------------------------------------------------------------
	// line drivers
	// ------------------------------------------------------------
	int         qt   = 256;    // quarter bit time in ns
	logic [6:0] own7 = 7'h50;  // only address the slave answers
	// pull-ups keep both lines high while nobody drives them
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// start or repeated start, made by the master only
	task automatic cond_start();
		sda = 1'b1;
		#qt scl = 1'b1;
		#qt sda = 1'b0;
		#qt scl = 1'b0;
		#qt;
	endtask
	// stop, then the bus rests high
	task automatic cond_stop();
		sda = 1'b0;
		#qt scl = 1'b1;
		#qt sda = 1'b1;
		#(2*qt);
	endtask
	// one bit, data set while the clock is low
	task automatic put_bit(input logic b);
		sda = b;
		#qt scl = 1'b1;
		#(2*qt) scl = 1'b0;
		#qt;
	endtask
	// byte msb first, then the receiver's ack; a nack leaves sda released
	task automatic put_byte(input logic [7:0] d, input logic ack);
		for (int i = 7; i >= 0; i--)
			put_bit(d[i]);
		put_bit(~ack);
	endtask
	// short address; the slave acks its own address only
	task automatic put_addr7(input logic [6:0] a, input logic rw);
		put_byte({a, rw}, a == own7);
	endtask
endmodule
`default_nettype wire

// ---- dv/i2c_bus_trigger_decoder_tb.sv ----
/*
  self-checking bench of the two-wire bus trigger decoder.
  assumes i2ctd_top and the bus model i2ctd_bus_bfm are compiled first.
*/
`default_nettype none
module i2c_bus_trigger_decoder_tb import i2ctd_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic             ref_clk      = 1'b0;
	logic             acq_clk      = 1'b0;
	logic             rst          = 1'b1;
	logic             dec_en       = 1'b0;
	logic             scl;
	logic             sda;
	logic [NCH-1:0]   ch_in;
	i2ctd_trig_e      trig_type    = TT_START;
	i2ctd_rw_e        rw_cond      = RW_EITHER;
	logic             addr_10bit   = 1'b0;
	logic [9:0]       addr_val     = 10'h000;
	logic             nack_addr_en = 1'b0;
	logic             nack_wr_en   = 1'b0;
	logic             nack_rd_en   = 1'b0;
	logic [PAT_W-1:0] data_pat     = '0;
	logic [3:0]       data_len     = 4'h0;
	logic [7:0]       data_index   = 8'h00;
	logic             trig_q;
	logic             ev_vld;
	i2ctd_ev_s        ev_out;
	i2ctd_ev_s        evq[$];
	int               ntrig        = 0;
	int               cycles       = 0;
	int               fails        = 0;
	int               n_compared   = 0;

	// clocks of unrelated phase
	always #4 ref_clk = ~ref_clk;
	initial
	begin
		#2.7;
		forever #32 acq_clk = ~acq_clk;
	end
	// decoys on the unused channels
	assign ch_in = {~scl, scl, sda, ~sda};

	i2ctd_bus_bfm bfm_u (.scl(scl), .sda(sda));
	i2ctd_top dut_u (
		.ref_clk(ref_clk), .rst(rst), .acq_clk(acq_clk), .ch_in(ch_in), .dec_en(dec_en),
		.scl_src(2'h2), .sda_src(2'h1), .trig_type(trig_type), .rw_cond(rw_cond),
		.addr_10bit(addr_10bit), .addr_val(addr_val), .nack_addr_en(nack_addr_en),
		.nack_wr_en(nack_wr_en), .nack_rd_en(nack_rd_en), .data_pat(data_pat),
		.data_len(data_len), .data_index(data_index), .trig_q(trig_q), .ev_vld(ev_vld),
		.ev_out(ev_out));

	// ------------------------------------------------------------
	// monitor, compares and closing
	// ------------------------------------------------------------
	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// collect events and trigger pulses, cut a hang short
	always @(negedge ref_clk)
	begin
		cycles++;
		if (ev_vld === 1'b1)
			evq.push_back(ev_out);
		if (trig_q === 1'b1)
			ntrig++;
		if (cycles == 70000)
		begin
			fails++;
			$display("mismatch at %0t: run timed out", $time);
			finish_test();
		end
	end
	task automatic chk_n(input int got, input int exp);
		n_compared++;
		if (got != exp)
		begin
			fails++;
			$display("mismatch at %0t: count %0d, expected %0d", $time, got, exp);
		end
	endtask
	task automatic chk_ev(input int i, input i2ctd_kind_e k, input logic [9:0] v,
			input logic a, input logic r);
		i2ctd_ev_s  e;
		logic [9:0] gv;
		logic       bad;
		n_compared++;
		e = (i < evq.size()) ? evq[i] : '0;
		gv = (k == EV_ADDR) ? e.addr : {2'h0, e.data};
		bad = (i >= evq.size()) || (e.kind !== k);
		if (k inside {EV_ADDR, EV_AHI, EV_DATA} && {gv, e.ack, e.rw} !== {v, a, r})
			bad = 1'b1;
		if (k == EV_ABORT && e.incomp !== 1'b1)
			bad = 1'b1;
		if (k inside {EV_START, EV_RSTART, EV_STOP} && e.incomp !== 1'b0)
			bad = 1'b1;
		if (bad)
		begin
			fails++;
			$display("mismatch at %0t: event %0d differs", $time, i);
		end
	endtask
	task automatic clr();
		evq.delete();
		ntrig = 0;
	endtask
	task automatic settle();
		repeat (100) @(negedge ref_clk);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic scn_short_write();
		@(negedge ref_clk);
		trig_type = TT_ADDR;
		rw_cond = RW_WRITE;
		addr_val = 10'h050;
		clr();
		bfm_u.cond_start();
		bfm_u.put_addr7(7'h50, 1'b0);
		bfm_u.put_byte(8'ha5, 1'b1);
		bfm_u.cond_stop();
		settle();
		chk_ev(0, EV_START, 10'h000, 1'b0, 1'b0);
		chk_ev(1, EV_ADDR, 10'h050, 1'b1, 1'b0);
		chk_ev(2, EV_DATA, 10'h0a5, 1'b1, 1'b0);
		chk_ev(3, EV_STOP, 10'h000, 1'b0, 1'b0);
		chk_n(evq.size(), 4);
		chk_n(ntrig, 1);
	endtask
	task automatic scn_read_nack();
		bfm_u.qt = 192;
		@(negedge ref_clk);
		trig_type = TT_NACK;
		nack_addr_en = 1'b1;
		nack_rd_en = 1'b1;
		clr();
		bfm_u.cond_start();
		bfm_u.put_addr7(7'h23, 1'b1);
		bfm_u.cond_start();
		bfm_u.put_addr7(7'h50, 1'b1);
		bfm_u.put_byte(8'h3c, 1'b1);
		bfm_u.put_byte(8'hc3, 1'b0);
		bfm_u.cond_stop();
		settle();
		chk_ev(1, EV_ADDR, 10'h023, 1'b0, 1'b1);
		chk_ev(2, EV_RSTART, 10'h000, 1'b0, 1'b0);
		chk_ev(4, EV_DATA, 10'h03c, 1'b1, 1'b1);
		chk_ev(5, EV_DATA, 10'h0c3, 1'b0, 1'b1);
		chk_n(evq.size(), 7);
		chk_n(ntrig, 2);
	endtask
	task automatic scn_long_addr();
		@(negedge ref_clk);
		trig_type = TT_ADDR;
		rw_cond = RW_READ;
		addr_10bit = 1'b1;
		addr_val = 10'h134;
		clr();
		bfm_u.cond_start();
		bfm_u.put_byte(8'hf2, 1'b1);
		bfm_u.put_byte(8'h34, 1'b1);
		bfm_u.cond_start();
		bfm_u.put_byte(8'hf3, 1'b1);
		bfm_u.put_byte(8'h77, 1'b0);
		bfm_u.cond_stop();
		settle();
		chk_ev(1, EV_AHI, 10'h0f2, 1'b1, 1'b0);
		chk_ev(2, EV_ADDR, 10'h134, 1'b1, 1'b0);
		chk_ev(4, EV_ADDR, 10'h134, 1'b1, 1'b1);
		chk_ev(5, EV_DATA, 10'h077, 1'b0, 1'b1);
		chk_n(ntrig, 1);
	endtask
	task automatic scn_conds();
		i2ctd_trig_e tt[3] = '{TT_START, TT_RSTART, TT_STOP};
		foreach (tt[i])
		begin
			@(negedge ref_clk);
			trig_type = tt[i];
			clr();
			bfm_u.cond_start();
			bfm_u.put_addr7(7'h50, 1'b0);
			bfm_u.cond_start();
			bfm_u.put_addr7(7'h50, 1'b1);
			bfm_u.cond_stop();
			settle();
			chk_n(ntrig, 1);
		end
	endtask
	task automatic scn_pattern(input i2ctd_trig_e tt, input logic [9:0] a, input int exp);
		logic [7:0] dat[5] = '{8'hbb, 8'hcc, 8'h11, 8'hbb, 8'hcc};
		@(negedge ref_clk);
		trig_type = tt;
		rw_cond = RW_EITHER;
		addr_10bit = 1'b0;
		addr_val = a;
		data_pat = 64'h0000_0000_0000_bbcc;
		data_len = 4'h2;
		data_index = 8'h01;
		clr();
		bfm_u.cond_start();
		bfm_u.put_addr7(7'h50, 1'b0);
		foreach (dat[i])
			bfm_u.put_byte(dat[i], 1'b1);
		bfm_u.cond_stop();
		settle();
		chk_n(ntrig, exp);
	endtask
	task automatic scn_disable();
		@(negedge ref_clk);
		trig_type = TT_STOP;
		clr();
		bfm_u.cond_start();
		bfm_u.put_bit(1'b1);
		bfm_u.put_bit(1'b0);
		@(negedge ref_clk);
		dec_en = 1'b0;
		settle();
		bfm_u.put_byte(8'h00, 1'b1);
		bfm_u.cond_stop();
		settle();
		chk_ev(1, EV_ABORT, 10'h000, 1'b0, 1'b0);
		chk_n(evq.size(), 2);
		chk_n(ntrig, 0);
	endtask

	// reset, then the scenarios in turn
	initial
	begin
		repeat (10) @(negedge ref_clk);
		repeat (3) @(posedge acq_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		dec_en = 1'b1;
		settle();
		scn_short_write();
		scn_read_nack();
		scn_long_addr();
		scn_conds();
		scn_pattern(TT_DATA, 10'h050, 1);
		scn_pattern(TT_ADDR_DATA, 10'h051, 0);
		scn_pattern(TT_ADDR_DATA, 10'h050, 1);
		scn_disable();
		finish_test();
	end
endmodule
`default_nettype wire
